/* File: dswc_defs.svh */
/*
 Register offsets, field positions, reset values and status bit positions
 for the drive status word composer.
 Assumes byte addressing on a 32-bit Avalon-MM register bus.
*/
`ifndef DSWC_DEFS_SVH
`define DSWC_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define DSWC_OFS_STATUS 6'h00
`define DSWC_OFS_CMD 6'h04
`define DSWC_OFS_CTRL 6'h08
`define DSWC_OFS_IRQ_STAT 6'h0C
`define DSWC_OFS_IRQ_EN 6'h10
`define DSWC_OFS_IRQ_CLR 6'h14

// ----------------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------------
`define DSWC_SB_READY 0
`define DSWC_SB_ENERGISED 1
`define DSWC_SB_RUNNING 2
`define DSWC_SB_TRIPPED 3
`define DSWC_SB_COAST_N 4
`define DSWC_SB_FAST_N 5
`define DSWC_SB_INHIBIT 6
`define DSWC_SB_REMOTE 9
`define DSWC_SB_AT_SP 10
`define DSWC_SB_LIMIT 11

// Command word bit positions
`define DSWC_CB_COAST_N 1
`define DSWC_CB_FAST_N 2

// Control register field positions
`define DSWC_CTRL_REM_SEL 0

// Interrupt events: status word changed, tripped rose
`define DSWC_EV_CHANGE 0
`define DSWC_EV_TRIP 1
`define DSWC_NEV 2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DSWC_RST_WORD 16'h0000
`define DSWC_RST_CMD 16'h0000
`define DSWC_RST_CTRL 1'h0
`define DSWC_RST_IRQ 2'h0

`endif

/* File: dswc_pkg.sv */
/*
 Types shared by the drive status word composer.
 Assumes dswc_defs.svh is on the include path.
*/
`default_nettype none

package dswc_pkg;

   // Sequencer states as seen by the composer
   typedef enum logic [2:0] {
      DSWC_ST_POWER_UP,
      DSWC_ST_INHIBIT,
      DSWC_ST_READY,
      DSWC_ST_SWITCHED_ON,
      DSWC_ST_OP_READY,
      DSWC_ST_ENABLED,
      DSWC_ST_FAST_STOP,
      DSWC_ST_TRIP
   } dswc_seq_state_e;

   // Drive control mode
   typedef enum logic {
      DSWC_MODE_VECTOR,
      DSWC_MODE_VHZ
   } dswc_ctl_mode_e;

   // Inputs from the sequencer and the ramp and limit logic
   typedef struct packed {
      logic ready_pwr;
      logic energised;
      logic running;
      logic tripped;
      logic coast_stop_n;
      logic fast_stop_n;
      dswc_seq_state_e state;
      logic remote_mode;
      logic ramping;
      logic torque_limit;
      logic current_limit;
      dswc_ctl_mode_e mode;
   } dswc_drive_s;

   // Avalon-MM request bundle
   typedef struct packed {
      logic [5:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
   } dswc_avm_req_s;

endpackage : dswc_pkg

`default_nettype wire

/* File: dswc_sync.sv */
/*
 Two-flip-flop synchroniser bank for the drive-side status inputs.
 Assumes the inputs are levels from logic outside the control clock.
*/
`timescale 1ns/1ps
`default_nettype none

module dswc_sync #(
   parameter int W = 8
) (
   input wire logic mclk, // Control clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic [W-1:0] din, // Asynchronous levels
   output logic [W-1:0] dout // Synchronised levels
);

   // ----------------------------------------------------------------------
   // Stages
   // ----------------------------------------------------------------------
   logic [W-1:0] meta_q; // First stage, read only by the second
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_q; // Second stage
   logic [W-1:0] sync_d;

   // Next values
   always_comb begin
      meta_d = din;
      sync_d = meta_q;
   end

   // Registers
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign dout = sync_q;

endmodule : dswc_sync

`default_nettype wire

/* File: dswc_top.sv */
/*
 Drive status word composer: assembles the 16-bit drive status word,
 holds the remote command word and remote select, and serves them over
 an Avalon-MM slave with waitrequest, plus a level interrupt.
 Assumes drive inputs come from outside the control clock domain and are
 synchronised here; the bus is on mclk.
*/
`timescale 1ns/1ps
`default_nettype none

`include "dswc_defs.svh"

module dswc_top
   import dswc_pkg::*;
(
   input wire logic mclk, // Control clock, 100 MHz
   input wire logic rstn, // Synchronous reset, active low
   input wire dswc_drive_s drive_in, // Sequencer and ramp inputs
   input wire logic [5:0] avs_address, // Byte address
   input wire logic avs_read, // Read strobe
   input wire logic avs_write, // Write strobe
   input wire logic [31:0] avs_writedata, // Write data
   input wire logic [3:0] avs_byteenable, // Byte lanes
   output logic [31:0] avs_readdata, // Read data
   output logic avs_waitrequest, // Stall, low on answer
   output logic [15:0] status_word, // Registered status word
   output logic [15:0] cmd_word, // Command word to sequencer
   output logic remote_sel, // Remote comms select
   output logic irq // Level interrupt
);

   // ----------------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------------
   dswc_drive_s drv; // Synchronised drive inputs

   dswc_sync #(.W($bits(dswc_drive_s))) u_sync (
      .mclk(mclk),
      .rstn(rstn),
      .din(drive_in),
      .dout(drv)
   );

   // ----------------------------------------------------------------------
   // Control state
   // ----------------------------------------------------------------------
   logic [15:0] word_q; // Status snapshot
   logic [15:0] word_d;
   logic [15:0] cmd_q; // Command word
   logic [15:0] cmd_d;
   logic rsel_q; // Remote comms select
   logic rsel_d;
   logic [`DSWC_NEV-1:0] ist_q; // Sticky interrupt status
   logic [`DSWC_NEV-1:0] ist_d;
   logic [`DSWC_NEV-1:0] ien_q; // Interrupt enable
   logic [`DSWC_NEV-1:0] ien_d;
   logic irq_q; // Interrupt output
   logic irq_d;
   logic [31:0] rd_q; // Read data
   logic [31:0] rd_d;
   logic ack_q; // Answer cycle, waitrequest low
   logic ack_d;
   logic [15:0] new_word; // Assembled word before snapshot
   logic [`DSWC_NEV-1:0] ev; // Events this cycle
   logic [`DSWC_NEV-1:0] clr; // Software clear this cycle
   logic wr_go; // Write accepted this cycle
   logic remote_cmd; // Remote comms sequencing in force

   // ----------------------------------------------------------------------
   // Status word assembly
   // ----------------------------------------------------------------------
   // Remote sequencing uses the command word for the stop bits
   always_comb begin
      remote_cmd = drv.remote_mode & rsel_q;
      new_word = `DSWC_RST_WORD;
      new_word[`DSWC_SB_READY] = drv.ready_pwr;
      new_word[`DSWC_SB_ENERGISED] = drv.energised;
      new_word[`DSWC_SB_RUNNING] = drv.running;
      new_word[`DSWC_SB_TRIPPED] = drv.tripped;
      if (remote_cmd) begin
         // Stop requests come from the master's command word
         new_word[`DSWC_SB_COAST_N] = cmd_q[`DSWC_CB_COAST_N];
         new_word[`DSWC_SB_FAST_N] = cmd_q[`DSWC_CB_FAST_N];
      end else begin
         // Stop requests come from the sequencer inputs
         new_word[`DSWC_SB_COAST_N] = drv.coast_stop_n;
         new_word[`DSWC_SB_FAST_N] = drv.fast_stop_n;
      end
      new_word[`DSWC_SB_INHIBIT] = (drv.state == DSWC_ST_INHIBIT);
      new_word[`DSWC_SB_REMOTE] = remote_cmd;
      new_word[`DSWC_SB_AT_SP] = ~drv.ramping;
      // Limit source depends on control mode
      if (drv.mode == DSWC_MODE_VECTOR) begin
         new_word[`DSWC_SB_LIMIT] = drv.torque_limit;
      end else begin
         new_word[`DSWC_SB_LIMIT] = drv.current_limit;
      end
   end

   // ----------------------------------------------------------------------
   // Bus decode and register next values
   // ----------------------------------------------------------------------
   // Requests are answered one cycle after they appear
   // Writes land at the edge that sees waitrequest low, as the master expects
   always_comb begin
      wr_go = avs_write & ack_q;
      ack_d = (avs_read | avs_write) & ~ack_q;
      word_d = new_word;
      cmd_d = cmd_q;
      rsel_d = rsel_q;
      ien_d = ien_q;
      clr = '0;
      rd_d = 32'h0000_0000;
      if (wr_go) begin
         if (avs_address == `DSWC_OFS_CMD) begin
            // Command word from the master, lanes 0 and 1
            if (avs_byteenable[0]) begin
               cmd_d[7:0] = avs_writedata[7:0];
            end
            if (avs_byteenable[1]) begin
               cmd_d[15:8] = avs_writedata[15:8];
            end
         end else if (avs_address == `DSWC_OFS_CTRL) begin
            // Remote comms select
            if (avs_byteenable[0]) begin
               rsel_d = avs_writedata[`DSWC_CTRL_REM_SEL];
            end
         end else if (avs_address == `DSWC_OFS_IRQ_EN) begin
            // Interrupt enable
            if (avs_byteenable[0]) begin
               ien_d = avs_writedata[`DSWC_NEV-1:0];
            end
         end else if (avs_address == `DSWC_OFS_IRQ_CLR) begin
            // Write one to clear
            if (avs_byteenable[0]) begin
               clr = avs_writedata[`DSWC_NEV-1:0];
            end
         end
         // Other addresses: write ignored
      end
      if (avs_read & ~ack_q) begin
         if (avs_address == `DSWC_OFS_STATUS) begin
            rd_d[15:0] = word_q;
         end else if (avs_address == `DSWC_OFS_CMD) begin
            rd_d[15:0] = cmd_q;
         end else if (avs_address == `DSWC_OFS_CTRL) begin
            rd_d[0] = rsel_q;
         end else if (avs_address == `DSWC_OFS_IRQ_STAT) begin
            rd_d[`DSWC_NEV-1:0] = ist_q;
         end else if (avs_address == `DSWC_OFS_IRQ_EN) begin
            rd_d[`DSWC_NEV-1:0] = ien_q;
         end
         // Unmapped and clear register read zero
      end
   end

   // ----------------------------------------------------------------------
   // Interrupt next values
   // ----------------------------------------------------------------------
   // Events set sticky bits; a set wins over a clear in the same cycle
   always_comb begin
      ev = '0;
      ev[`DSWC_EV_CHANGE] = (new_word != word_q);
      ev[`DSWC_EV_TRIP] = drv.tripped & ~word_q[`DSWC_SB_TRIPPED];
      ist_d = (ist_q & ~clr) | ev;
      irq_d = |(ist_d & ien_d);
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         word_q <= `DSWC_RST_WORD;
         cmd_q <= `DSWC_RST_CMD;
         rsel_q <= `DSWC_RST_CTRL;
         ist_q <= `DSWC_RST_IRQ;
         ien_q <= `DSWC_RST_IRQ;
         irq_q <= 1'b0;
         rd_q <= 32'h0000_0000;
         ack_q <= 1'b0;
      end else begin
         word_q <= word_d;
         cmd_q <= cmd_d;
         rsel_q <= rsel_d;
         ist_q <= ist_d;
         ien_q <= ien_d;
         irq_q <= irq_d;
         rd_q <= rd_d;
         ack_q <= ack_d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign avs_readdata = rd_q;
   assign avs_waitrequest = ~ack_q;
   assign status_word = word_q;
   assign cmd_word = cmd_q;
   assign remote_sel = rsel_q;
   assign irq = irq_q;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   a_unused_zero: assert property (@(posedge mclk)
      disable iff (!rstn)
      (word_q[8:7] == 2'h0) && (word_q[15:12] == 4'h0))
      else $error("unsupported status bits not zero");

   a_ready_bit: assert property (@(posedge mclk) disable iff (!rstn)
      word_q[`DSWC_SB_READY] == $past(drv.ready_pwr))
      else $error("bit 0 does not follow ready output");

   a_energ_bit: assert property (@(posedge mclk) disable iff (!rstn)
      word_q[`DSWC_SB_ENERGISED] == $past(drv.energised))
      else $error("bit 1 does not follow energised output");

   a_run_bit: assert property (@(posedge mclk) disable iff (!rstn)
      word_q[`DSWC_SB_RUNNING] == $past(drv.running))
      else $error("bit 2 does not follow running output");

   a_trip_bit: assert property (@(posedge mclk) disable iff (!rstn)
      drv.tripped |=> word_q[`DSWC_SB_TRIPPED])
      else $error("bit 3 missed a trip");

   a_coast_remote: assert property (@(posedge mclk)
      disable iff (!rstn)
      (drv.remote_mode && rsel_q) |=>
      word_q[`DSWC_SB_COAST_N] == $past(cmd_q[`DSWC_CB_COAST_N]))
      else $error("bit 4 wrong in remote mode");

   a_fast_local: assert property (@(posedge mclk)
      disable iff (!rstn)
      !(drv.remote_mode && rsel_q) |=>
      word_q[`DSWC_SB_FAST_N] == $past(drv.fast_stop_n))
      else $error("bit 5 wrong in local mode");

   a_coast_local: assert property (@(posedge mclk)
      disable iff (!rstn)
      !(drv.remote_mode && rsel_q) |=>
      word_q[`DSWC_SB_COAST_N] == $past(drv.coast_stop_n))
      else $error("bit 4 wrong in local mode");

   a_fast_remote: assert property (@(posedge mclk)
      disable iff (!rstn)
      (drv.remote_mode && rsel_q) |=>
      word_q[`DSWC_SB_FAST_N] == $past(cmd_q[`DSWC_CB_FAST_N]))
      else $error("bit 5 wrong in remote mode");

   a_inhibit_bit: assert property (@(posedge mclk)
      disable iff (!rstn)
      word_q[`DSWC_SB_INHIBIT] == ($past(drv.state) == DSWC_ST_INHIBIT))
      else $error("bit 6 wrong for sequencer state");

   a_remote_bit: assert property (@(posedge mclk)
      disable iff (!rstn)
      word_q[`DSWC_SB_REMOTE] == $past(drv.remote_mode && rsel_q))
      else $error("bit 9 wrong");

   a_setpoint_bit: assert property (@(posedge mclk)
      disable iff (!rstn)
      drv.ramping |=> !word_q[`DSWC_SB_AT_SP])
      else $error("bit 10 set while ramping");

   a_limit_bit: assert property (@(posedge mclk)
      disable iff (!rstn)
      (drv.mode == DSWC_MODE_VHZ && drv.current_limit) |=>
      word_q[`DSWC_SB_LIMIT])
      else $error("bit 11 missed current limit");

   a_cmd_write: assert property (@(posedge mclk)
      disable iff (!rstn)
      (avs_write && !avs_waitrequest && avs_address == `DSWC_OFS_CMD &&
      avs_byteenable[1:0] == 2'h3) |=> cmd_q == $past(avs_writedata[15:0]))
      else $error("command word write lost");

   a_status_read: assert property (@(posedge mclk)
      disable iff (!rstn)
      (avs_read && !ack_q && avs_address == `DSWC_OFS_STATUS) |=>
      (avs_readdata[15:0] == $past(word_q)) && !avs_waitrequest)
      else $error("status read not coherent");

   // A trip edge must stick even when software clears in the same cycle
   a_trip_sticky: assert property (@(posedge mclk)
      disable iff (!rstn)
      (drv.tripped && !word_q[`DSWC_SB_TRIPPED]) |=> ist_q[`DSWC_EV_TRIP])
      else $error("trip event lost");

   // Interrupt line is high exactly while an enabled status bit is set
   a_irq_level: assert property (@(posedge mclk)
      disable iff (!rstn)
      irq_q == |(ist_q & ien_q))
      else $error("interrupt level wrong");

   c_lane_write: cover property (@(posedge mclk) disable iff (!rstn)
      avs_write && !avs_waitrequest && avs_byteenable != 4'hF);

   c_remote_seq: cover property (@(posedge mclk) disable iff (!rstn)
      word_q[`DSWC_SB_REMOTE] && word_q[`DSWC_SB_RUNNING]);

   c_trip_irq: cover property (@(posedge mclk) disable iff (!rstn)
      ist_q[`DSWC_EV_TRIP] && irq_q);

   c_status_read: cover property (@(posedge mclk) disable iff (!rstn)
      avs_read && !avs_waitrequest && avs_address == `DSWC_OFS_STATUS);

endmodule : dswc_top

`default_nettype wire

/* File: dswc_master_model.sv */
/*
 Avalon-MM master model standing in for the remote fieldbus master.
 Assumes the slave answers by dropping waitrequest for one cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module dswc_master_model (
   input wire logic mclk, // Control clock
   input wire logic avs_waitrequest, // Slave stall
   output logic [5:0] avs_address, // Byte address
   output logic avs_read, // Read strobe
   output logic avs_write, // Write strobe
   output logic [31:0] avs_writedata, // Write data
   output logic [3:0] avs_byteenable // Byte lanes
);
   // ---------------------------------------------------------------
   // Idle bus
   // ---------------------------------------------------------------
   initial begin
      avs_address = 6'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'hF;
   end

   // One transfer, held until waitrequest is sampled low
   task automatic xfer(input logic wr_en, input logic [5:0] a,
         input logic [31:0] d, input logic [3:0] be);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= !wr_en;
      avs_write <= wr_en; // Command word arrives by writes
      do begin
         @(posedge mclk);
      end while (avs_waitrequest);
      // Released lines show the inverse, not the old value
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_address <= ~a;
      avs_writedata <= ~d;
      avs_byteenable <= ~be;
   endtask : xfer
endmodule : dswc_master_model

`default_nettype wire

/* File: tb_top.sv */
/*
 Self-checking bench for the drive status word composer.
 Assumes dswc_defs.svh on the include path and the master model.
*/
`timescale 1ns/1ps
`default_nettype none

`include "dswc_defs.svh"

module tb_top
   import dswc_pkg::*;
;
   logic mclk = 1'b0; // Control clock
   logic rstn = 1'b0; // Reset, active low
   dswc_drive_s drv = '0; // Drive-side levels
   logic [5:0] avs_address; // Bus address
   logic avs_read; // Read strobe
   logic avs_write; // Write strobe
   logic [31:0] avs_writedata; // Write data
   logic [3:0] avs_byteenable; // Byte lanes
   logic [31:0] avs_readdata; // Read data
   logic avs_waitrequest; // Stall
   logic [15:0] status_word; // Status snapshot
   logic [15:0] cmd_word; // Command word
   logic remote_sel; // Remote select
   logic irq; // Interrupt
   int mismatches = 0; // Failed comparisons
   int checks = 0; // Comparisons made
   int cycles = 0; // Run length
   integer seed = 32'h4bff; // Fixed seed
   logic [31:0] exp_q[$]; // Expected read data

   always #5 mclk = ~mclk;

   dswc_top uut (.mclk(mclk), .rstn(rstn), .drive_in(drv),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .status_word(status_word),
      .cmd_word(cmd_word), .remote_sel(remote_sel), .irq(irq));

   dswc_master_model m (.mclk(mclk), .avs_waitrequest(avs_waitrequest),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable));

   // ---------------------------------------------------------------
   // Reporting
   // ---------------------------------------------------------------
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test

   // Read data against its note
   task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch readdata exp %h got %h", e, g);
      end
   endtask : cmp_rd

   // Output port against expectation
   task automatic cmp_port(input string n, input logic [15:0] e,
         input logic [15:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask : cmp_port

   // Hang guard
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         mismatches++;
         stop_test();
      end
   end

   // Monitor: each answered read takes the oldest note
   always @(posedge mclk) begin
      if (avs_read && !avs_waitrequest) begin
         if (exp_q.size() > 0) begin
            cmp_rd(exp_q.pop_front(), avs_readdata);
         end else begin
            cmp_rd(32'hFFFFFFFF, avs_readdata);
         end
      end
   end

   // ---------------------------------------------------------------
   // Bus helpers and expected status word
   // ---------------------------------------------------------------
   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      m.xfer(1'b0, a, 32'h00000000, 4'hF);
   endtask : rd

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      m.xfer(1'b1, a, d, 4'hF);
   endtask : wr

   // Inputs need three edges through the synchroniser
   task automatic settle;
      repeat (5) @(posedge mclk);
   endtask : settle

   function automatic logic [15:0] exp_word(input dswc_drive_s d,
         input logic [15:0] c, input logic s);
      logic sel;
      logic [15:0] w;
      sel = d.remote_mode & s;
      w = 16'h0000; // Unsupported bits stay zero
      w[0] = d.ready_pwr;
      w[1] = d.energised;
      w[2] = d.running;
      w[3] = d.tripped;
      w[4] = sel ? c[1] : d.coast_stop_n;
      w[5] = sel ? c[2] : d.fast_stop_n;
      w[6] = (d.state == DSWC_ST_INHIBIT);
      w[9] = sel;
      w[10] = !d.ramping;
      w[11] = (d.mode == DSWC_MODE_VECTOR) ? d.torque_limit
         : d.current_limit;
      return w;
   endfunction : exp_word

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [31:0] r;
      logic [15:0] cmd;
      logic ctl;
      logic [15:0] w;
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      // Reset values, write-only and unmapped places read zero
      rd(`DSWC_OFS_CMD, 32'h00000000);
      rd(`DSWC_OFS_CTRL, 32'h00000000);
      rd(`DSWC_OFS_IRQ_EN, 32'h00000000);
      rd(`DSWC_OFS_IRQ_CLR, 32'h00000000);
      rd(6'h3C, 32'h00000000);
      // Random drive levels, command word and remote select
      for (int i = 0; i < 40; i++) begin
         r = $random(seed);
         drv <= dswc_drive_s'(r[$bits(dswc_drive_s)-1:0]);
         r = $random(seed);
         cmd = r[15:0];
         ctl = r[16];
         wr(`DSWC_OFS_CMD, {16'h0000, cmd});
         wr(`DSWC_OFS_CTRL, {31'h00000000, ctl});
         wr(`DSWC_OFS_STATUS, 32'hFFFFFFFF); // Read-only place
         wr(6'h3C, 32'h0000FFFF); // Unmapped place
         settle();
         w = exp_word(drv, cmd, ctl);
         cmp_port("status_word", w, status_word);
         cmp_port("cmd_word", cmd, cmd_word);
         cmp_port("remote_sel", {15'h0000, ctl}, {15'h0000, remote_sel});
         cmp_port("irq", 16'h0000, {15'h0000, irq});
         rd(`DSWC_OFS_STATUS, {16'h0000, w});
         rd(`DSWC_OFS_CMD, {16'h0000, cmd});
      end
      // Lane 0 only: the upper command byte keeps its value
      m.xfer(1'b1, `DSWC_OFS_CMD, 32'h0000A55A, 4'h1);
      rd(`DSWC_OFS_CMD, {16'h0000, cmd[15:8], 8'h5A});
      // No lanes: the remote select write is ignored
      m.xfer(1'b1, `DSWC_OFS_CTRL, {31'h00000000, !ctl}, 4'h0);
      rd(`DSWC_OFS_CTRL, {31'h00000000, ctl});
      // Interrupt: raise on trip, clear, enable and mask
      drv <= '0;
      settle();
      wr(`DSWC_OFS_IRQ_CLR, 32'h00000003);
      wr(`DSWC_OFS_IRQ_EN, 32'h00000002);
      rd(`DSWC_OFS_IRQ_STAT, 32'h00000000);
      cmp_port("irq", 16'h0000, {15'h0000, irq});
      drv.tripped <= 1'b1;
      settle();
      cmp_port("irq", 16'h0001, {15'h0000, irq});
      rd(`DSWC_OFS_IRQ_STAT, 32'h00000003);
      wr(`DSWC_OFS_IRQ_CLR, 32'h00000002);
      rd(`DSWC_OFS_IRQ_STAT, 32'h00000001);
      repeat (2) @(posedge mclk);
      cmp_port("irq", 16'h0000, {15'h0000, irq});
      wr(`DSWC_OFS_IRQ_EN, 32'h00000001);
      repeat (2) @(posedge mclk);
      cmp_port("irq", 16'h0001, {15'h0000, irq});
      wr(`DSWC_OFS_IRQ_EN, 32'h00000000);
      repeat (2) @(posedge mclk);
      cmp_port("irq", 16'h0000, {15'h0000, irq});
      wr(`DSWC_OFS_IRQ_CLR, 32'h00000001);
      rd(`DSWC_OFS_IRQ_STAT, 32'h00000000);
      repeat (3) @(posedge mclk);
      cmp_port("pending_reads", 16'h0000, 16'(exp_q.size()));
      stop_test();
   end
endmodule : tb_top

`default_nettype wire
